/* File: rtl/calendar_clock_defs.svh */
// Purpose: offsets, field positions, reset values and codes of the calendar clock
// Assumes: byte addresses, one 32-bit word per register
// Notes:   the alias operation sits in address bits 3:2
`ifndef CALENDAR_CLOCK_DEFS_SVH
`define CALENDAR_CLOCK_DEFS_SVH
`define OFS_CONTROL_A     8'h00
`define OFS_CONTROL_B     8'h10
`define OFS_STATUS        8'h30
`define OFS_TIME          8'h40
`define OFS_DATE          8'h50
`define OFS_ALARM_TIME    8'h60
`define OFS_ALARM_DATE    8'h70
`define CONTROL_A_MASK    32'hCFFF_88F0
`define CONTROL_B_MASK    32'hFFFF_F803
`define ALARM_DATE_MASK   32'h001F_3F07
`define CONTROL_RESET     32'h0000_0000
`define BIT_ALARM_ENABLE  31
`define BIT_CHIME         30
`define POS_INTERVAL      24
`define POS_REPEAT        16
`define BIT_ON            15
`define BIT_WRITE_LOCK    11
`define BIT_PIN_ENABLE    7
`define POS_PIN_SELECT    4
`define POS_DIVIDE        16
`define POS_FRACTION      11
`define POS_SOURCE        0
`define BIT_ALARM_EVENT   5
`define BIT_SYNC          2
`define BIT_ALARM_SYNC    1
`define BIT_HALF          0
`define IVL_HALF_SECOND   4'h0
`define IVL_SECOND        4'h1
`define IVL_TEN_SECONDS   4'h2
`define IVL_MINUTE        4'h3
`define IVL_TEN_MINUTES   4'h4
`define IVL_HOUR          4'h5
`define IVL_DAY           4'h6
`define IVL_WEEK          4'h7
`define IVL_MONTH         4'h8
`define IVL_YEAR          4'h9
`define SRC_CRYSTAL       2'h0
`define SRC_INTERNAL      2'h1
`define SRC_PIN           2'h2
`define SRC_PERIPHERAL    2'h3
`define PIN_ALARM         3'h0
`define PIN_SECONDS       3'h1
`define PIN_DIVIDED       3'h2
`define SEC_LAST          8'h59
`define HOUR_LAST         8'h23
`define MONTH_LAST        8'h12
`define YEAR_LAST         8'h99
`define WEEKDAY_LAST      3'h6
`define FRACTION_WRAP     5'h1F
`define SYNC_WINDOW       17'h0_0020
`endif

/* File: rtl/calendar_clock_pkg.sv */
// Purpose: types shared by the calendar clock
// Assumes: every field is one BCD digit
// Notes:   tens digits are kept 4 bits wide; hour, minute, day and month tens are trimmed on the register view
package calendar_clock_pkg;
    typedef struct packed {
        logic [3:0] hr_t, hr_o, min_t, min_o, sec_t, sec_o;
    } time_s;
    typedef struct packed {
        logic [3:0] yr_t, yr_o, mth_t, mth_o, day_t, day_o;
        logic [2:0] weekday_field;
    } date_s;
    typedef enum logic [1:0] {op_write, op_clear, op_set, op_invert} alias_op_e;
endpackage

/* File: rtl/calendar_clock_with_alarm.sv */
// Purpose: real-time clock, calendar and alarm behind a plain register port
// Assumes: timebase sources are at most a quarter of the clock rate
// Notes:   time and date registers hold BCD digits
// Behaviour
// - hours count zero to twenty-three
// - half-second indicator visible in status
// - calendar 2000-2099 with leap-year correction
// - all fields held as BCD digits
// - interval codes zero to eight select period
// - code nine yearly, February 29th quadrennial
// - alarm enable gates alarm events
// - chime lets repeat count wrap
// - without chime, count stops at zero
// - count decrements on every alarm event except at zero without chime
// - four timebase sources supported
// - two-bit field selects timebase source
// - divide value sets half-second period
// - fractional calibration lengthens period periodically
// - pin shows alarm, seconds or divided clock
// - clear, set, invert aliases per register
// - defined register values after reset
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "calendar_clock_defs.svh"
module calendar_clock_with_alarm #(
    parameter int ADDR_WIDTH = 8
) (
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic [ADDR_WIDTH-1:0] address,
    input  wire logic [31:0]           write_data,
    input  wire logic                  write_strobe,
    input  wire logic                  read_strobe,
    output logic      [31:0]           read_data,
    input  wire logic                  secondary_crystal_osc,
    input  wire logic                  low_power_internal_osc,
    input  wire logic                  external_timebase_pin,
    output logic                       pin_out,
    output logic                       pin_drive_n
);
    if (ADDR_WIDTH < 7) begin : g_check
        $error("address too narrow for the register map");
    end

    calendar_clock_pkg::time_s     tm, next_tm, atm, next_atm;
    calendar_clock_pkg::date_s     dt, next_dt, adt, next_adt;
    calendar_clock_pkg::alias_op_e op;
    logic [31:0]           ctl_a, next_ctl_a, ctl_b, next_ctl_b, next_read_data;
    logic [16:0]           cnt, next_cnt, reload;
    logic [4:0]            frac, next_frac;
    logic                  half, next_half, half_chk, sec_chk, evt, next_evt;
    logic                  next_pin_out, src_tick, half_tick, sec_tick, fire, c;
    logic [8:0]            s;
    logic [2:0]            pin_raw, pin_meta, pin_sync, pin_prev, edges;
    logic [ADDR_WIDTH-1:0] base;
    logic [3:0]            ivl;
    logic [7:0]            rpt;
    logic                  locked, m_s1, m_s, m_m1, m_m, m_h, m_w, m_d, m_mo;

    function automatic logic [8:0] bcd_step(input logic [7:0] v, last, first);
        if (v == last) return {1'b1, first};
        if (v[3:0] == 4'h9) return {1'b0, v[7:4] + 4'h1, 4'h0};
        return {1'b0, v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] month_last(input logic [7:0] mth, yr);
        logic leap;
        // every year of 2000-2099 divisible by four is a leap year
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mth)
            8'h02: return leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction

    function automatic logic [31:0] time_word(input calendar_clock_pkg::time_s t);
        return {1'b0, t.hr_t[2:0], t.hr_o, 1'b0, t.min_t[2:0], t.min_o,
                t.sec_t, t.sec_o, 8'h00};
    endfunction

    function automatic calendar_clock_pkg::time_s word_time(input logic [31:0] w);
        return {1'b0, w[30:28], w[27:24], 1'b0, w[22:20], w[19:16], w[15:12], w[11:8]};
    endfunction

    function automatic logic [31:0] date_word(input calendar_clock_pkg::date_s d);
        return {d.yr_t, d.yr_o, 3'b000, d.mth_t[0], d.mth_o, 2'b00, d.day_t[1:0],
                d.day_o, 5'b00000, d.weekday_field};
    endfunction

    function automatic calendar_clock_pkg::date_s word_date(input logic [31:0] w);
        return {w[31:28], w[27:24], 3'b000, w[20], w[19:16], 2'b00, w[13:12],
                w[11:8], w[2:0]};
    endfunction

    function automatic logic [31:0] apply(input logic [31:0] old, wd,
                                          input calendar_clock_pkg::alias_op_e o);
        unique case (o)
            calendar_clock_pkg::op_write:  return wd;
            calendar_clock_pkg::op_clear:  return old & ~wd;
            calendar_clock_pkg::op_set:    return old | wd;
            calendar_clock_pkg::op_invert: return old ^ wd;
        endcase
    endfunction

    // the first stage is read only by the second; edges come from stage two and three
    assign pin_raw = {external_timebase_pin, low_power_internal_osc, secondary_crystal_osc};
    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                pin_meta[i] <= 1'b0;
                pin_sync[i] <= 1'b0;
                pin_prev[i] <= 1'b0;
            end else begin
                pin_meta[i] <= pin_raw[i];
                pin_sync[i] <= pin_meta[i];
                pin_prev[i] <= pin_sync[i];
            end
        end
    end
    assign edges = pin_sync & ~pin_prev;

    assign base   = {address[ADDR_WIDTH-1:4], 4'h0};
    assign op     = calendar_clock_pkg::alias_op_e'(address[3:2]);
    assign ivl    = ctl_a[`POS_INTERVAL +: 4];
    assign rpt    = ctl_a[`POS_REPEAT +: 8];
    assign locked = ctl_a[`BIT_WRITE_LOCK];

    always_comb begin
        unique case (ctl_b[`POS_SOURCE +: 2])
            `SRC_CRYSTAL:  src_tick = edges[0];
            `SRC_INTERNAL: src_tick = edges[1];
            `SRC_PIN:      src_tick = edges[2];
            `SRC_PERIPHERAL: src_tick = 1'b1;
        endcase
    end

    // calibration stretches one half-second in every thirty-two (16 s)
    assign reload = (frac == `FRACTION_WRAP)
                  ? 17'({1'b0, ctl_b[`POS_DIVIDE +: 16]} + 17'(ctl_b[`POS_FRACTION +: 5]))
                  : {1'b0, ctl_b[`POS_DIVIDE +: 16]};
    assign half_tick = ctl_a[`BIT_ON] && src_tick && cnt == 17'h0_0000;
    assign sec_tick  = half_tick && half;

    // matches use the registered time one cycle after the tick
    assign m_s1 = tm.sec_o == atm.sec_o;
    assign m_s  = m_s1 && tm.sec_t == atm.sec_t;
    assign m_m1 = m_s && tm.min_o == atm.min_o;
    assign m_m  = m_m1 && tm.min_t == atm.min_t;
    assign m_h  = m_m && tm.hr_t == atm.hr_t && tm.hr_o == atm.hr_o;
    assign m_w  = m_h && dt.weekday_field == adt.weekday_field;
    assign m_d  = m_h && dt.day_t == adt.day_t && dt.day_o == adt.day_o;
    assign m_mo = m_d && dt.mth_t == adt.mth_t && dt.mth_o == adt.mth_o;

    always_comb begin
        case (ivl)
            `IVL_HALF_SECOND: fire = half_chk;
            `IVL_SECOND:      fire = sec_chk;
            `IVL_TEN_SECONDS: fire = sec_chk && m_s1;
            `IVL_MINUTE:      fire = sec_chk && m_s;
            `IVL_TEN_MINUTES: fire = sec_chk && m_m1;
            `IVL_HOUR:        fire = sec_chk && m_m;
            `IVL_DAY:         fire = sec_chk && m_h;
            `IVL_WEEK:        fire = sec_chk && m_w;
            `IVL_MONTH:       fire = sec_chk && m_d;
            `IVL_YEAR:        fire = sec_chk && m_mo;
            default:          fire = 1'b0;
        endcase
        fire = fire && ctl_a[`BIT_ALARM_ENABLE];
    end

    always_comb begin
        next_tm = tm;
        next_dt = dt;
        next_atm = atm;
        next_adt = adt;
        next_ctl_a = ctl_a;
        next_ctl_b = ctl_b;
        next_cnt = cnt;
        next_frac = frac;
        next_half = half;
        c = 1'b0;
        s = 9'h000;
        if (ctl_a[`BIT_ON] && src_tick) begin
            next_cnt = (cnt == 17'h0_0000) ? reload : cnt - 17'h0_0001;
        end
        if (half_tick) begin
            next_half = ~half;
            next_frac = frac + 5'h01;
        end
        if (sec_tick) begin
            s = bcd_step({tm.sec_t, tm.sec_o}, `SEC_LAST, 8'h00);
            {next_tm.sec_t, next_tm.sec_o} = s[7:0];
            c = s[8];
            if (c) begin
                s = bcd_step({tm.min_t, tm.min_o}, `SEC_LAST, 8'h00);
                {next_tm.min_t, next_tm.min_o} = s[7:0];
                c = s[8];
            end
            if (c) begin
                s = bcd_step({tm.hr_t, tm.hr_o}, `HOUR_LAST, 8'h00);
                {next_tm.hr_t, next_tm.hr_o} = s[7:0];
                c = s[8];
            end
            if (c) begin
                next_dt.weekday_field = (dt.weekday_field == `WEEKDAY_LAST)
                                      ? 3'h0 : dt.weekday_field + 3'h1;
                s = bcd_step({dt.day_t, dt.day_o},
                             month_last({dt.mth_t, dt.mth_o}, {dt.yr_t, dt.yr_o}),
                             8'h01);
                {next_dt.day_t, next_dt.day_o} = s[7:0];
                c = s[8];
            end
            if (c) begin
                s = bcd_step({dt.mth_t, dt.mth_o}, `MONTH_LAST, 8'h01);
                {next_dt.mth_t, next_dt.mth_o} = s[7:0];
                c = s[8];
            end
            if (c) begin
                s = bcd_step({dt.yr_t, dt.yr_o}, `YEAR_LAST, 8'h00);
                {next_dt.yr_t, next_dt.yr_o} = s[7:0];
            end
        end
        if (fire) begin
            // without chime the last event also retires the alarm
            if (rpt == 8'h00 && !ctl_a[`BIT_CHIME]) begin
                next_ctl_a[`BIT_ALARM_ENABLE] = 1'b0;
            end else begin
                next_ctl_a[`POS_REPEAT +: 8] = rpt - 8'h01;
            end
        end
        // a software write in the same cycle overrides the hardware update
        if (write_strobe) begin
            if (base == ADDR_WIDTH'(`OFS_CONTROL_A)) begin
                next_ctl_a = apply(ctl_a, write_data, op) & `CONTROL_A_MASK;
            end
            if (base == ADDR_WIDTH'(`OFS_CONTROL_B) && !locked) begin
                next_ctl_b = apply(ctl_b, write_data, op) & `CONTROL_B_MASK;
            end
            if (base == ADDR_WIDTH'(`OFS_TIME) && !locked) begin
                next_tm = word_time(apply(time_word(tm), write_data, op));
            end
            if (base == ADDR_WIDTH'(`OFS_DATE) && !locked) begin
                next_dt = word_date(apply(date_word(dt), write_data, op));
            end
            if (base == ADDR_WIDTH'(`OFS_ALARM_TIME)) begin
                next_atm = word_time(apply(time_word(atm), write_data, op));
            end
            if (base == ADDR_WIDTH'(`OFS_ALARM_DATE)) begin
                next_adt = word_date(apply(date_word(adt), write_data, op)
                                     & `ALARM_DATE_MASK);
            end
        end
    end

    always_comb begin
        next_read_data = 32'h0000_0000;
        // reading status clears the event flag, but a new event wins
        next_evt = fire || (evt && !(read_strobe && base == ADDR_WIDTH'(`OFS_STATUS)));
        if (read_strobe) begin
            case (base)
                ADDR_WIDTH'(`OFS_CONTROL_A):  next_read_data = ctl_a;
                ADDR_WIDTH'(`OFS_CONTROL_B):  next_read_data = ctl_b;
                ADDR_WIDTH'(`OFS_STATUS): begin
                    next_read_data[`BIT_ALARM_EVENT] = evt;
                    next_read_data[`BIT_SYNC] = ctl_a[`BIT_ON] && cnt < `SYNC_WINDOW;
                    next_read_data[`BIT_ALARM_SYNC] = ctl_a[`BIT_ON] && cnt < `SYNC_WINDOW
                                                      && ctl_a[`BIT_ALARM_ENABLE];
                    next_read_data[`BIT_HALF] = half;
                end
                ADDR_WIDTH'(`OFS_TIME):       next_read_data = time_word(tm);
                ADDR_WIDTH'(`OFS_DATE):       next_read_data = date_word(dt);
                ADDR_WIDTH'(`OFS_ALARM_TIME): next_read_data = time_word(atm);
                ADDR_WIDTH'(`OFS_ALARM_DATE): next_read_data = date_word(adt) & `ALARM_DATE_MASK;
                default:                      next_read_data = 32'h0000_0000;
            endcase
        end
        case (ctl_a[`POS_PIN_SELECT +: 3])
            `PIN_ALARM:   next_pin_out = fire;
            `PIN_SECONDS: next_pin_out = half;
            `PIN_DIVIDED: next_pin_out = half_tick;
            default:      next_pin_out = 1'b0;
        endcase
        next_pin_out = next_pin_out && ctl_a[`BIT_PIN_ENABLE];
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tm <= '0;
            dt <= '0;
            atm <= '0;
            adt <= '0;
            ctl_a <= `CONTROL_RESET;
            ctl_b <= `CONTROL_RESET;
            cnt <= 17'h0_0000;
            frac <= 5'h00;
            half <= 1'b0;
            half_chk <= 1'b0;
            sec_chk <= 1'b0;
            evt <= 1'b0;
            read_data <= 32'h0000_0000;
            pin_out <= 1'b0;
            pin_drive_n <= 1'b1;
        end else begin
            tm <= next_tm;
            dt <= next_dt;
            atm <= next_atm;
            adt <= next_adt;
            ctl_a <= next_ctl_a;
            ctl_b <= next_ctl_b;
            cnt <= next_cnt;
            frac <= next_frac;
            half <= next_half;
            half_chk <= half_tick;
            sec_chk <= sec_tick;
            evt <= next_evt;
            read_data <= next_read_data;
            pin_out <= next_pin_out;
            pin_drive_n <= ~ctl_a[`BIT_PIN_ENABLE];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    sequence status_read_s;
        read_strobe && base == ADDR_WIDTH'(`OFS_STATUS);
    endsequence
    sequence day_end_s;
        sec_tick && !write_strobe && time_word(tm) == 32'h2359_5900;
    endsequence

    hour_wrap_a: assert property (day_end_s |=> time_word(tm) == 32'h0000_0000)
        else $error("hours did not wrap to zero after 23:59:59");
    half_visible_a: assert property (status_read_s |=> read_data[`BIT_HALF] == $past(half))
        else $error("status half indicator differs from internal state");
    leap_day_a: assert property (day_end_s and ({dt.mth_t, dt.mth_o} == 8'h02
        && {dt.day_t, dt.day_o} == 8'h28 && {dt.yr_t, dt.yr_o} == 8'h24)
        |=> {dt.day_t, dt.day_o} == 8'h29)
        else $error("leap year february did not reach the 29th");
    sec_roll_a: assert property (sec_tick && !write_strobe && {tm.sec_t, tm.sec_o} == 8'h59
        |=> {tm.sec_t, tm.sec_o} == 8'h00 && time_word(tm) != $past(time_word(tm)))
        else $error("seconds did not roll over with carry");
    every_second_a: assert property (ivl == `IVL_SECOND && ctl_a[`BIT_ALARM_ENABLE] && sec_chk
        |-> fire)
        else $error("per-second alarm missed");
    yearly_match_a: assert property (fire && ivl == `IVL_YEAR
        |-> time_word(tm) == time_word(atm)
        && {dt.mth_t, dt.mth_o} == {adt.mth_t, adt.mth_o}
        && {dt.day_t, dt.day_o} == {adt.day_t, adt.day_o})
        else $error("yearly alarm fired without month and date match");
    event_flag_a: assert property (fire |=> evt ##1 1'b1)
        else $error("alarm event not recorded");
    gate_off_a: assert property (!ctl_a[`BIT_ALARM_ENABLE] && !write_strobe |=> !evt || $past(evt))
        else $error("alarm event while alarm disabled");
    chime_wrap_a: assert property (fire && rpt == 8'h00 && ctl_a[`BIT_CHIME] && !write_strobe
        |=> rpt == 8'hFF && ctl_a[`BIT_ALARM_ENABLE])
        else $error("chime repeat count did not wrap");
    repeat_stop_a: assert property (fire && rpt == 8'h00 && !ctl_a[`BIT_CHIME] && !write_strobe
        |=> rpt == 8'h00 && !ctl_a[`BIT_ALARM_ENABLE])
        else $error("repeat count passed zero without chime");
    repeat_dec_a: assert property (fire && rpt != 8'h00 && !write_strobe
        |=> rpt == $past(rpt) - 8'h01)
        else $error("repeat count did not decrement");
    periph_count_a: assert property (ctl_b[`POS_SOURCE +: 2] == `SRC_PERIPHERAL && ctl_a[`BIT_ON]
        && cnt != 17'h0_0000 |=> cnt == $past(cnt) - 17'h0_0001)
        else $error("divider did not count on the peripheral clock");
    calib_reload_a: assert property (half_tick && frac == `FRACTION_WRAP && !write_strobe
        |=> cnt == 17'({1'b0, ctl_b[`POS_DIVIDE +: 16]}) + 17'(ctl_b[`POS_FRACTION +: 5]))
        else $error("calibrated reload value wrong");
    seconds_pin_a: assert property (ctl_a[`BIT_PIN_ENABLE] && ctl_a[`POS_PIN_SELECT +: 3]
        == `PIN_SECONDS |=> pin_out == $past(half) && !pin_drive_n)
        else $error("seconds clock not on pin");
    alias_set_a: assert property (write_strobe && base == ADDR_WIDTH'(`OFS_CONTROL_B) && !locked
        && op == calendar_clock_pkg::op_set
        |=> ctl_b == (($past(ctl_b) | $past(write_data)) & `CONTROL_B_MASK))
        else $error("set alias did not OR in the written bits");
endmodule // calendar_clock_with_alarm

/* File: tb/test_calendar_clock_with_alarm.sv */
// Purpose: self-checking bench for the calendar clock with alarm
// Assumes: fast timebase from small divide values and the peripheral clock
// Notes:   a table-driven register pass, then hand-written timing and alarm tests
`timescale 1ns/1ps
module test_calendar_clock_with_alarm;
    logic        clock        = 1'b0;
    logic        reset        = 1'b1;
    logic [7:0]  address      = 8'h00;
    logic [31:0] write_data   = 32'h0000_0000;
    logic        write_strobe = 1'b0;
    logic        read_strobe  = 1'b0;
    logic [7:0]  osc_count    = 8'h00;
    logic [31:0] read_data;
    logic        pin_out;
    logic        pin_drive_n;
    logic [31:0] d;
    logic [31:0] h;
    int          num_errors   = 0;
    int          comparisons  = 0;
    // access address, write data, value read back at the base address
    logic [31:0] rows [13][3] = '{
        '{32'h10, 32'hFFFF_FFFF, 32'hFFFF_F803}, '{32'h14, 32'h0000_0003, 32'hFFFF_F800},
        '{32'h1C, 32'hFFFF_0000, 32'h0000_F800}, '{32'h18, 32'h0001_0003, 32'h0001_F803},
        '{32'h70, 32'hFFFF_FFFF, 32'h001F_3F07}, '{32'h74, 32'h001F_3F07, 32'h0000_0000},
        '{32'h60, 32'hFFFF_FFFF, 32'h7F7F_FF00}, '{32'h64, 32'hFFFF_FFFF, 32'h0000_0000},
        '{32'h30, 32'hFFFF_FFFF, 32'h0000_0000}, '{32'h80, 32'hFFFF_FFFF, 32'h0000_0000},
        '{32'h08, 32'h4000_0000, 32'h4000_0000}, '{32'h0C, 32'hC000_0000, 32'h8000_0000},
        '{32'h04, 32'hFFFF_FFFF, 32'h0000_0000}};
    // date before midnight and date after: leap year, common year, end of century
    logic [31:0] dates [3][2] = '{'{32'h2402_2806, 32'h2402_2900},
        '{32'h2302_2801, 32'h2303_0102}, '{32'h9912_3103, 32'h0001_0104}};

    calendar_clock_with_alarm calendar_clock_with_alarm_inst (
        .clock(clock), .reset(reset), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .secondary_crystal_osc(osc_count[3]), .low_power_internal_osc(osc_count[4]),
        .external_timebase_pin(osc_count[2]), .pin_out(pin_out), .pin_drive_n(pin_drive_n));

    initial begin
        forever #4 clock = ~clock;
    end

    // slow timebases, all well under a quarter of the clock rate
    always_ff @(posedge clock) begin
        osc_count <= osc_count + 8'h01;
    end

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        address <= a;
        write_data <= v;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1 v = read_data;
    endtask

    // reads until the masked value leaves v; a stuck design runs the loop out
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
                        output logic [31:0] q);
        for (int i = 0; i < 1000; i++) begin
            rd(a, q);
            if ((q & m) !== v) break;
        end
    endtask

    initial begin
        #400_000;
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        test_done();
    end

    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        chk(32'(pin_drive_n), 32'h0000_0001);
        for (int k = 0; k < 8; k++) begin
            rd(8'(k * 16), d);
            chk(d, 32'h0000_0000);
        end
        $display("reset values done");
        for (int k = 0; k < 13; k++) begin
            wr(rows[k][0][7:0], rows[k][1]);
            rd(rows[k][0][7:0] & 8'hF0, d);
            chk(d, rows[k][2]);
        end
        $display("register pass done");
        for (int s = 0; s < 3; s++) begin
            wr(8'h00, 32'h0000_0000);
            wr(8'h10, 32'(s));
            wr(8'h00, 32'h0000_8000);
            rd(8'h30, h);
            poll(8'h30, 32'h0000_0001, h & 32'h0000_0001, d);
            chk(d & 32'h0000_0001, ~h & 32'h0000_0001);
        end
        $display("timebase sources done");
        wr(8'h10, 32'h0009_0003);
        for (int k = 0; k < 3; k++) begin
            wr(8'h00, 32'h0000_0000);
            wr(8'h40, 32'h2359_5900);
            wr(8'h50, dates[k][0]);
            wr(8'h00, 32'h0000_8000);
            poll(8'h40, 32'hFFFF_FFFF, 32'h2359_5900, d);
            chk(d, 32'h0000_0000);
            rd(8'h50, d);
            chk(d, dates[k][1]);
        end
        $display("rollover done");
        wr(8'h10, 32'h0001_0003);
        rd(8'h30, d);
        wr(8'h00, 32'h0100_8000);
        repeat (40) @(posedge clock);
        rd(8'h30, d);
        chk(d & 32'h0000_0020, 32'h0000_0000);
        wr(8'h00, 32'h8A00_8000);
        repeat (40) @(posedge clock);
        rd(8'h00, d);
        chk(d, 32'h8A00_8000);
        wr(8'h00, 32'h8102_8000);
        repeat (60) @(posedge clock);
        rd(8'h00, d);
        chk(d, 32'h0100_8000);
        rd(8'h30, d);
        chk(d & 32'h0000_0020, 32'h0000_0020);
        // slower seconds so one poll cannot miss a half-second alarm
        wr(8'h10, 32'h0009_0003);
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, 32'hC000_8000 | (32'(c) << 24));
            poll(8'h00, 32'h00FF_0000, 32'h0000_0000, d);
            chk(d, 32'hC0FF_8000 | (32'(c) << 24));
        end
        // yearly alarm on february 29th, reached through the leap-day rollover
        wr(8'h00, 32'h0000_0000);
        wr(8'h40, 32'h2359_5800);
        wr(8'h50, 32'h2402_2806);
        wr(8'h60, 32'h0000_0000);
        wr(8'h70, 32'h0002_2900);
        rd(8'h30, d);
        wr(8'h00, 32'h8900_8000);
        poll(8'h00, 32'h8000_0000, 32'h8000_0000, d);
        chk(d, 32'h0900_8000);
        rd(8'h30, d);
        chk(d & 32'h0000_0020, 32'h0000_0020);
        $display("alarm done");
        wr(8'h00, 32'h0000_0080);
        repeat (2) @(posedge clock);
        chk(32'(pin_drive_n), 32'h0000_0000);
        wr(8'h00, 32'h0000_8090);
        #1;
        for (int i = 0; i < 200 && pin_out !== 1'b1; i++) #8;
        chk(32'(pin_out), 32'h0000_0001);
        wr(8'h00, 32'h0000_0800);
        wr(8'h10, 32'h0000_0000);
        rd(8'h10, d);
        chk(d, 32'h0009_0003);
        wr(8'h00, 32'h0000_0000);
        $display("pin and lock done");
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rd(8'h10, d);
        chk(d, 32'h0000_0000);
        $display("second reset done");
        test_done();
    end
endmodule // test_calendar_clock_with_alarm
